// File: src/console_pkg.sv
// console switch control package: register offsets, reset values, states and carriers
// assumes a single processor clock domain and an 18-bit bus address path
package console_pkg;

    // =====================================================================
    // widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    // =====================================================================
    // register offsets, byte addresses on the register bus
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IREG_BASE = 8'h04;
    localparam logic [7:0] OFS_LATCH = 8'h08;
    localparam logic [7:0] OFS_DATA_DISP = 8'h0c;
    localparam logic [7:0] OFS_ADDR_DISP = 8'h10;

    // =====================================================================
    // reset values and address steps
    localparam logic [17:0] IREG_BASE_RST = 18'h3ffc0;
    localparam int IREG_SPAN_BITS = 4;
    localparam logic [17:0] WORD_STEP = 18'h00002;
    localparam logic [17:0] IREG_STEP = 18'h00001;
    localparam logic [17:0] ADDR_RST = 18'h00000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // =====================================================================
    // control states and last console operation
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HALTING = 3'b001,
        ST_CONSOLE = 3'b010,
        ST_STEP = 3'b011,
        ST_BUS = 3'b100
    } state_e;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_EXAMINE_KEY = 2'b01,
        OP_DEP = 2'b10
    } last_op_e;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic halt_sel;
        logic load_address_key;
        logic examine_key;
        logic deposit_key;
        logic continue_key;
        logic start_key;
    } keys_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

endpackage

// File: src/console_ctrl.sv
// console switch control: run/halt selector, keys, console address latch,
// examine/deposit bus cycles and an AHB-Lite register window
// assumes keys are debounced levels synchronous to hclk, and the processor
// reports instruction boundaries with instr_done and pending traps with trap_pending
//
// How it works
// R1: latch holds its value while program runs
// R2: repeated examine or deposit increments latch and address
// R3: odd addresses lose bit 00, word access
// R4: odd byte shows in data bits 15..08
// R5: continue at enable resumes the processor
// R6: continue at halt runs exactly one instruction
// R7: continue never issues a system clear
// R8: at enable no requests, keys ignored
// R9: halt after instruction and traps, before grants
// R10: start always clears; at halt no start
// R11: start release at enable runs from latch
// R12: deposit writes switch value to latched address
// R13: displays show written data and address
// R14: consecutive deposits target the next address
// R15: load or examine cancels deposit increment
// R16: bus timeout ends quietly, no trap
// R17: load address copies switches into latch
// R18: first access after halt/load never increments
// R19: increment is one word, two bytes
// R20: internal register addresses increment by one
// R21: examine reads latched word into displays
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module console_ctrl (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // front panel
    input wire console_pkg::keys_s keys,
    input wire logic [17:0] switch_reg,
    output logic [17:0] addr_display,
    output logic [15:0] data_display,
    // processor control
    input wire logic instr_done,
    input wire logic trap_pending,
    input wire logic prog_halt,
    output logic cpu_run,
    output logic console_mode,
    output logic hold_priority_grants,
    output logic sys_clear,
    output logic start_load,
    output logic [17:0] start_addr,
    // system bus cycles
    output console_pkg::bus_req_s bus_req,
    input wire logic bus_ack,
    input wire logic bus_timeout,
    input wire logic [15:0] bus_rdata
);

    // =====================================================================
    // state
    console_pkg::state_e state_r, state_nxt;
    console_pkg::last_op_e last_op_r;
    console_pkg::keys_s keys_q_r;
    console_pkg::bus_req_s bus_req_r;
    logic [17:0] latch_r;
    logic [17:0] bar_r;
    logic [15:0] data_disp_r;
    logic [17:0] ireg_base_r;
    logic start_armed_r;
    logic cpu_run_r;
    logic console_mode_r;
    logic hold_r;
    logic sys_clear_r;
    logic start_load_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;

    // =====================================================================
    // key edges; deposit acts on the press, start clears on press, runs on release
    wire press_load = keys.load_address_key & ~keys_q_r.load_address_key;
    wire press_examine_key = keys.examine_key & ~keys_q_r.examine_key;
    wire press_dep = keys.deposit_key & ~keys_q_r.deposit_key;
    wire press_cont = keys.continue_key & ~keys_q_r.continue_key;
    wire press_start = keys.start_key & ~keys_q_r.start_key;
    wire rel_start = ~keys.start_key & keys_q_r.start_key;

    // =====================================================================
    // key acceptance: only the stopped console listens, panel keys need halt
    wire in_console = (state_r == console_pkg::ST_CONSOLE);
    wire panel_ok = in_console & keys.halt_sel; // R8
    wire do_load = panel_ok & press_load; // R17
    wire do_examine_key = panel_ok & press_examine_key & ~press_load;
    wire do_dep = panel_ok & press_dep & ~press_load & ~press_examine_key;
    wire panel_busy = do_load | do_examine_key | do_dep;
    wire do_cont = in_console & press_cont & ~panel_busy;
    wire do_start = in_console & press_start & ~panel_busy & ~press_cont;
    wire do_go = in_console & start_armed_r & rel_start & ~keys.halt_sel; // R11
    wire boundary = instr_done & ~trap_pending; // R9

    // =====================================================================
    // address stepping: words by two, internal registers by one
    localparam int IREG_SPAN_BITS_L = console_pkg::IREG_SPAN_BITS;
    wire lat_ireg = (latch_r[17:IREG_SPAN_BITS_L] == ireg_base_r[17:IREG_SPAN_BITS_L]);
    wire [17:0] step_amt = lat_ireg ? console_pkg::IREG_STEP : console_pkg::WORD_STEP; // R19 R20
    wire [17:0] inc_addr = latch_r + step_amt;
    wire examine_key_inc = (last_op_r == console_pkg::OP_EXAMINE_KEY); // R18
    wire dep_inc = (last_op_r == console_pkg::OP_DEP); // R14 R15
    wire [17:0] examine_key_addr = examine_key_inc ? inc_addr : latch_r; // R2
    wire [17:0] dep_addr = dep_inc ? inc_addr : latch_r; // R2
    wire [17:0] sel_addr = do_examine_key ? examine_key_addr : dep_addr;
    wire sel_ireg = (sel_addr[17:IREG_SPAN_BITS_L] == ireg_base_r[17:IREG_SPAN_BITS_L]);
    wire [17:0] bus_addr = sel_ireg ? sel_addr : {sel_addr[17:1], 1'b0}; // R3

    // =====================================================================
    // next state of the run/halt control
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            console_pkg::ST_RUN: begin
                if (prog_halt) begin
                    state_nxt = console_pkg::ST_CONSOLE;
                end else if (keys.halt_sel) begin
                    state_nxt = console_pkg::ST_HALTING; // R9
                end
            end
            console_pkg::ST_HALTING: begin
                if (boundary) begin
                    state_nxt = console_pkg::ST_CONSOLE; // R9
                end
            end
            console_pkg::ST_CONSOLE: begin
                if (do_examine_key | do_dep) begin
                    state_nxt = console_pkg::ST_BUS; // R12 R21
                end else if (do_cont) begin
                    state_nxt = keys.halt_sel ? console_pkg::ST_STEP : console_pkg::ST_RUN; // R5 R6
                end else if (do_go) begin
                    state_nxt = console_pkg::ST_RUN; // R11
                end
            end
            console_pkg::ST_STEP: begin
                if (boundary) begin
                    state_nxt = console_pkg::ST_CONSOLE; // R6
                end
            end
            console_pkg::ST_BUS: begin
                if (bus_ack | bus_timeout) begin
                    state_nxt = console_pkg::ST_CONSOLE; // R16
                end
            end
            default: begin
                state_nxt = console_pkg::ST_CONSOLE;
            end
        endcase
    end

    // decoded outputs of the next state
    wire run_nxt = (state_nxt == console_pkg::ST_RUN) | (state_nxt == console_pkg::ST_HALTING)
        | (state_nxt == console_pkg::ST_STEP);
    wire hold_nxt = (state_nxt == console_pkg::ST_HALTING) | (state_nxt == console_pkg::ST_STEP);
    wire cons_nxt = (state_nxt == console_pkg::ST_CONSOLE) | (state_nxt == console_pkg::ST_BUS);
    wire enter_halt = (state_nxt == console_pkg::ST_CONSOLE) & (state_r != console_pkg::ST_CONSOLE)
        & (state_r != console_pkg::ST_BUS);
    wire bus_done = (state_r == console_pkg::ST_BUS) & (bus_ack | bus_timeout);

    // =====================================================================
    // state, key history and processor control flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= console_pkg::ST_CONSOLE;
            keys_q_r <= '0;
            cpu_run_r <= 1'b0;
            hold_r <= 1'b0;
            console_mode_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            keys_q_r <= keys;
            cpu_run_r <= run_nxt; // R5 R6
            hold_r <= hold_nxt; // R9
            console_mode_r <= cons_nxt;
        end
    end

    // system clear on start press, program start on release at enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_clear_r <= 1'b0;
            start_load_r <= 1'b0;
            start_armed_r <= 1'b0;
        end else begin
            sys_clear_r <= do_start; // R7 R10
            start_load_r <= do_go; // R10 R11
            if (do_start) begin
                start_armed_r <= 1'b1;
            end else if (rel_start | ~in_console) begin
                start_armed_r <= 1'b0;
            end
        end
    end

    // =====================================================================
    // console address latch and the increment history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_r <= console_pkg::ADDR_RST;
            last_op_r <= console_pkg::OP_NONE;
        end else begin
            if (do_load) begin
                latch_r <= switch_reg; // R17
            end else if (do_examine_key | do_dep) begin
                latch_r <= sel_addr; // R2 R1
            end
            if (do_load | do_cont | do_start | enter_halt) begin
                last_op_r <= console_pkg::OP_NONE; // R15 R18
            end else if (do_examine_key) begin
                last_op_r <= console_pkg::OP_EXAMINE_KEY;
            end else if (do_dep) begin
                last_op_r <= console_pkg::OP_DEP;
            end
        end
    end

    // =====================================================================
    // bus cycle request and the address and data displays
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_req_r <= '0;
            bar_r <= console_pkg::ADDR_RST;
            data_disp_r <= console_pkg::DATA_RST;
        end else begin
            if (do_examine_key | do_dep) begin
                bus_req_r.valid <= 1'b1;
                bus_req_r.write <= do_dep; // R12
                bus_req_r.addr <= bus_addr; // R3
                bus_req_r.wdata <= switch_reg[15:0]; // R12
            end else if (bus_done) begin
                bus_req_r.valid <= 1'b0; // R16
            end
            if (do_load) begin
                bar_r <= switch_reg; // R17
            end else if (bus_done) begin
                bar_r <= bus_req_r.addr; // R13 R21
            end
            if (bus_done) begin
                // whole word shown, so an odd byte sits in bits 15..08
                data_disp_r <= bus_req_r.write ? bus_req_r.wdata : bus_rdata; // R4 R13 R21
            end
        end
    end

    // =====================================================================
    // register bus: zero wait states, always OKAY
    wire ahb_take = hsel & hready & (htrans == console_pkg::HTRANS_NONSEQ | htrans == 2'h3);
    wire [7:0] ofs = haddr[7:0];
    wire [31:0] status_word = {24'h000000, keys.halt_sel, cpu_run_r, last_op_r, 1'b0, state_r};
    wire [31:0] rd_mux = (ofs == console_pkg::OFS_STATUS) ? status_word :
        (ofs == console_pkg::OFS_IREG_BASE) ? {14'h0000, ireg_base_r} :
        (ofs == console_pkg::OFS_LATCH) ? {14'h0000, latch_r} :
        (ofs == console_pkg::OFS_DATA_DISP) ? {16'h0000, data_disp_r} :
        (ofs == console_pkg::OFS_ADDR_DISP) ? {14'h0000, bar_r} : 32'h00000000;

    // address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            wr_pend_r <= ahb_take & hwrite;
            wr_ofs_r <= ofs;
            if (ahb_take & ~hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    // data phase write; only the internal register base is writable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ireg_base_r <= console_pkg::IREG_BASE_RST;
        end else if (wr_pend_r & (wr_ofs_r == console_pkg::OFS_IREG_BASE)) begin
            ireg_base_r <= hwdata[17:0]; // R20
        end
    end

    // =====================================================================
    // outputs, all from flops
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign addr_display = bar_r;
    assign data_display = data_disp_r;
    assign cpu_run = cpu_run_r;
    assign console_mode = console_mode_r;
    assign hold_priority_grants = hold_r;
    assign sys_clear = sys_clear_r;
    assign start_load = start_load_r;
    assign start_addr = latch_r;
    assign bus_req = bus_req_r;

    // =====================================================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    latch_hold_a: assert property ((state_r == console_pkg::ST_RUN) |=> $stable(latch_r)) // R1
        else $error("latch changed while program runs");
    dep_step_a: assert property ((do_dep && dep_inc && !lat_ireg) |=> (latch_r == $past(latch_r) + 18'h00002)) // R2
        else $error("repeated deposit did not step one word");
    even_addr_a: assert property (((do_examine_key || do_dep) && !sel_ireg) |=> !bus_req_r.addr[0]) // R3
        else $error("odd address reached the bus");
    cont_resume_a: assert property ((do_cont && !keys.halt_sel) |=> (cpu_run_r && !console_mode_r)) // R5
        else $error("continue at enable did not resume");
    step_one_a: assert property ((state_r == console_pkg::ST_STEP && boundary) |=> (state_r == console_pkg::ST_CONSOLE && !cpu_run_r)) // R6
        else $error("single step did not stop at the boundary");
    cont_noclear_a: assert property (do_cont |=> !sys_clear_r) // R7
        else $error("continue issued a system clear");
    run_quiet_a: assert property ((state_r == console_pkg::ST_RUN) |=> (!bus_req_r.valid && !start_load_r)) // R8
        else $error("console active while program runs");
    halt_hold_a: assert property ((state_r == console_pkg::ST_HALTING && !boundary) |=> (hold_r && cpu_run_r)) // R9
        else $error("grants not held while halting");
    start_clear_a: assert property (do_start |=> sys_clear_r ##1 !sys_clear_r) // R10
        else $error("start press gave no single clear pulse");
    start_addr_a: assert property (do_go |=> (start_load_r && start_addr == $past(latch_r) && cpu_run_r)) // R11
        else $error("start release did not run from the latch");
    dep_data_a: assert property (do_dep |=> (bus_req_r.write && bus_req_r.wdata == $past(switch_reg[15:0]))) // R12
        else $error("deposit data is not the switch value");
    first_noinc_a: assert property (((do_examine_key && !examine_key_inc) || (do_dep && !dep_inc)) // R18
        |=> (latch_r == $past(latch_r)))
        else $error("first access after load incremented");
    timeout_end_a: assert property ((state_r == console_pkg::ST_BUS && bus_timeout) |=> (state_r == console_pkg::ST_CONSOLE && !bus_req_r.valid)) // R16
        else $error("timeout did not end the console cycle");

    dep_seq_c: cover property (do_dep ##[1:50] do_dep && dep_inc);
    examine_key_seq_c: cover property (do_examine_key ##[1:50] do_examine_key && examine_key_inc);
    step_c: cover property (do_cont && keys.halt_sel ##[1:50] state_r == console_pkg::ST_CONSOLE);
    start_c: cover property (do_start ##[1:50] do_go);

endmodule

`default_nettype wire

// File: verification/bus_target_model.sv
// bus target model: a word memory that answers console bus cycles
// assumes bus_req is registered by the console and held until ack or timeout
`timescale 1ns/100ps
`default_nettype none

module bus_target_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // console bus cycles
    input wire console_pkg::bus_req_s bus_req,
    input wire logic [1:0] delay,
    output logic bus_ack,
    output logic bus_timeout,
    output logic [15:0] bus_rdata
);
    // =====================================================================
    // storage: 256 words below 18'h00200, nothing answers above
    logic [15:0] mem [0:255];
    logic [1:0] wait_r;
    wire logic present = bus_req.addr[17:9] == 9'h000;
    wire logic [7:0] idx = bus_req.addr[8:1];

    // high byte differs from low byte so byte placement shows
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {~8'(i), 8'(i)};
        end
    end

    // answer after delay cycles; read data scrambles outside the answer cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_ack <= 1'b0;
            bus_timeout <= 1'b0;
            bus_rdata <= 16'h0000;
            wait_r <= 2'h0;
        end else begin
            bus_ack <= 1'b0;
            bus_timeout <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus_req.valid && !bus_ack && !bus_timeout) begin
                if (wait_r >= delay) begin
                    wait_r <= 2'h0;
                    bus_ack <= present;
                    bus_timeout <= !present;
                    if (present && !bus_req.write) bus_rdata <= mem[idx];
                    if (present && bus_req.write) mem[idx] <= bus_req.wdata;
                end else begin
                    wait_r <= wait_r + 2'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: verification/console_switch_control_tb_top.sv
// testbench for the console switch control: keys, bus cycles, register window
// assumes the bus target model answers every console bus cycle below 18'h00200 and times out the rest
`timescale 1ns/100ps
`default_nettype none

module console_switch_control_tb_top;
    // =====================================================================
    // signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, cpu_run, console_mode, hold_priority_grants, sys_clear, start_load, bus_ack, bus_timeout;
    console_pkg::keys_s keys = 6'h20;
    logic [17:0] switch_reg = 18'h0;
    logic [17:0] addr_display, start_addr, cur, sw;
    logic [15:0] data_display, bus_rdata;
    logic instr_done = 1'b0;
    logic trap_pending = 1'b0;
    logic prog_halt = 1'b0;
    logic [1:0] delay = 2'h0;
    console_pkg::bus_req_s bus_req;
    logic [15:0] shadow [0:255];
    int fail_count = 0, total_checks = 0, cycles = 0, clears = 0, starts = 0, c0, s0, last_op, op;

    always #25 hclk = ~hclk;

    console_ctrl console_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .keys(keys), .switch_reg(switch_reg), .addr_display(addr_display), .data_display(data_display),
        .instr_done(instr_done), .trap_pending(trap_pending), .prog_halt(prog_halt), .cpu_run(cpu_run),
        .console_mode(console_mode), .hold_priority_grants(hold_priority_grants), .sys_clear(sys_clear),
        .start_load(start_load), .start_addr(start_addr), .bus_req(bus_req), .bus_ack(bus_ack),
        .bus_timeout(bus_timeout), .bus_rdata(bus_rdata));

    bus_target_model bus_target_model_i (.hclk(hclk), .hresetn(hresetn), .bus_req(bus_req), .delay(delay),
        .bus_ack(bus_ack), .bus_timeout(bus_timeout), .bus_rdata(bus_rdata));

    // count clear and start pulses, cut a hang short
    always @(posedge hclk) begin
        cycles++;
        if (sys_clear === 1'b1) clears++;
        if (start_load === 1'b1) starts++;
        if (cycles == 20000) begin
            $display("Error at %0t: timeout", $time);
            fail_count++;
            give_verdict();
        end
    end

    // =====================================================================
    // tasks
    task automatic give_verdict;
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // expected address after an auto-increment: one inside the internal register window, a word elsewhere
    function automatic logic [17:0] next_addr(input logic [17:0] a);
        return (a[17:4] == 14'h3ff0) ? a + 18'h1 : a + 18'h2;
    endfunction

    // one single-word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= console_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    // press key k for one cycle with switches set, end settled after release
    task automatic key(input int k, input logic [17:0] s);
        @(posedge hclk);
        keys[k] <= 1'b1;
        switch_reg <= s;
        @(posedge hclk);
        keys[k] <= 1'b0;
        @(posedge hclk);
        #1;
    endtask

    // examine (k=3) or deposit (k=2): check the bus cycle and both displays
    task automatic access(input int k, input logic [17:0] s, input logic [17:0] ea, input logic [15:0] ed);
        key(k, s);
        chk(32'(bus_req.valid), 32'h1);
        chk(32'(bus_req.addr), 32'(ea));
        chk(32'(bus_req.write), 32'(k == 2));
        if (k == 2) chk(32'(bus_req.wdata), 32'(ed));
        for (int n = 0; n < 40 && bus_req.valid === 1'b1; n++) begin
            @(posedge hclk);
            #1;
        end
        chk({31'h0, console_mode}, 32'h1);
        chk(32'(addr_display), 32'(ea));
        chk(32'(data_display), 32'(ed));
    endtask

    task automatic pulse_done;
        @(posedge hclk);
        instr_done <= 1'b1;
        @(posedge hclk);
        instr_done <= 1'b0;
        #1;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(37085));
        for (int i = 0; i < 256; i++) shadow[i] = {~8'(i), 8'(i)};
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk({30'h0, console_mode, cpu_run}, 32'h2);
        chk(32'(addr_display), 32'h0);
        ahb(1'b0, console_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h82);
        ahb(1'b0, console_pkg::OFS_IREG_BASE, 32'h0);
        chk(rd, 32'(console_pkg::IREG_BASE_RST));
        ahb(1'b1, console_pkg::OFS_LATCH, 32'h155);
        ahb(1'b0, console_pkg::OFS_LATCH, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, console_pkg::OFS_IREG_BASE, 32'h3ff00);
        ahb(1'b0, console_pkg::OFS_IREG_BASE, 32'h0);
        chk(rd, 32'h3ff00);
        // random load, examine and deposit mix against a shadow memory
        cur = 18'h0;
        last_op = 0;
        for (int i = 0; i < 60; i++) begin
            op = $urandom_range(2, 4);
            sw = 18'($urandom);
            delay <= 2'($urandom);
            if (op == 4) begin
                sw = {10'h0, sw[7:0]};
                key(4, sw);
                chk(32'(start_addr), 32'(sw));
                chk(32'(addr_display), 32'(sw));
                cur = {sw[17:1], 1'b0};
            end else begin
                if (last_op == op) cur = next_addr(cur);
                if (op == 2) shadow[cur[8:1]] = sw[15:0];
                access(op, sw, cur, shadow[cur[8:1]]);
            end
            last_op = op;
        end
        // internal register window steps by one; unanswered cycles end quietly
        key(4, 18'h3ff05);
        access(2, 18'h1234, 18'h3ff05, 16'h1234);
        access(2, 18'h0abc, next_addr(18'h3ff05), 16'h0abc);
        chk({31'h0, cpu_run}, 32'h0);
        // start at halt clears but does not run
        c0 = clears;
        s0 = starts;
        key(0, 18'h0);
        repeat (3) @(posedge hclk);
        #1;
        chk(clears, c0 + 1);
        chk(starts, s0);
        chk({31'h0, cpu_run}, 32'h0);
        // single step waits for the pending trap, then runs one instruction
        @(posedge hclk);
        trap_pending <= 1'b1;
        key(1, 18'h0);
        chk({30'h0, cpu_run, hold_priority_grants}, 32'h3);
        pulse_done();
        chk({31'h0, cpu_run}, 32'h1);
        @(posedge hclk);
        trap_pending <= 1'b0;
        pulse_done();
        chk({30'h0, cpu_run, console_mode}, 32'h1);
        chk(clears, c0 + 1);
        // start at enable runs from the latch; keys ignored while running
        key(4, 18'h00124);
        @(posedge hclk);
        keys.halt_sel <= 1'b0;
        key(0, 18'h0);
        repeat (2) @(posedge hclk);
        #1;
        chk(starts, s0 + 1);
        chk(32'(start_addr), 32'h124);
        chk({30'h0, cpu_run, console_mode}, 32'h2);
        key(3, 18'h0);
        chk({31'h0, bus_req.valid}, 32'h0);
        pulse_done();
        chk(32'(start_addr), 32'h124);
        // halt selector stops at the next instruction boundary
        @(posedge hclk);
        keys.halt_sel <= 1'b1;
        @(posedge hclk);
        #1;
        chk({30'h0, cpu_run, hold_priority_grants}, 32'h3);
        pulse_done();
        chk({30'h0, cpu_run, console_mode}, 32'h1);
        // continue at enable resumes without a clear
        @(posedge hclk);
        keys.halt_sel <= 1'b0;
        key(1, 18'h0);
        pulse_done();
        chk({30'h0, cpu_run, console_mode}, 32'h2);
        chk(clears, c0 + 2);
        @(posedge hclk);
        prog_halt <= 1'b1;
        @(posedge hclk);
        prog_halt <= 1'b0;
        @(posedge hclk);
        #1;
        chk({31'h0, console_mode}, 32'h1);
        give_verdict();
    end
endmodule

`default_nettype wire
